//--- src/mic_irq_ctrl.sv
// Interrupt request, enable, vectoring and stack logic with APB registers
//
// Our own choices: the APB slave port and the placing of the registers.
`default_nettype none

// What this block does
// - Ext-pin-2/serial-1 register: flags bits 5,4, enables bits 1,0, rest zero.
// - Group-0 register: four timer flags in bits 7-4, enables 3-0.
// - Group-1 register: four timer flags in bits 7-4, enables 3-0.
// - EEPROM/low-voltage register: flags bits 5,4, enables bits 1,0.
// - Timer, low-voltage, EEPROM flags only cleared by software writes.
// - Flags set on events regardless of enable, except pin flag (needs pin enable) and group flag (needs member enable); vectoring needs the enable.
// - Global enable low blocks all vectoring.
// - Accepting pushes next PC, then loads the vector address.
// - Return pops the stack back into the program counter.
// - Service clears global enable; new requests still latch.
// - No acceptance while stack full; request stays pending.
// - Newly set flag wakes from sleep/idle; already set flag does not.
// - Pin flag set on the selected edge type; field can disable.
// - Pin acts as interrupt only if enabled, muxed to irq, and input.
// - Pin service clears its flag and the global enable.
// - Pull-high selection stays active on interrupt pins.
// - Comparator output change sets flag; service clears it and global enable.
// - Three groups; group flag set by member source, vectors when enabled.
// - Group service clears only group flag and global enable.
// - Edge field: 00 off, 01 rising, 10 falling, 11 both.
// - Global enable is bit 0 of first primary register, reset zero.
module mic_irq_ctrl
  import mic_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [mic_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire mic_pkg::mic_src_t          src,
  input  wire mic_pkg::mic_pin_t          pins,
  input  wire mic_pkg::mic_cpu_req_t      cpuReq,
  output mic_pkg::mic_cpu_rsp_t           cpuRsp,
  output logic [mic_pkg::NUM_EXT-1:0]     pullHighEn
);
  import mic_pkg::*;

  // ------------------------------------------------------------------
  // Pin and comparator edge detection
  // ------------------------------------------------------------------
  mic_state_t st_r;
  mic_state_t st_nxt;
  logic [NUM_EXT-1:0] pinEvt;
  logic               cmpEvt;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++)
    begin : gPin
      logic [EDGE_W-1:0] sel;
      logic              rise;
      logic              fall;
      logic              active;
      assign sel    = st_r.edgeSelectReg[gi*EDGE_W +: EDGE_W];
      assign rise   = pins.extIrqPins[gi] & ~st_r.pinPrev[gi];
      assign fall   = ~pins.extIrqPins[gi] & st_r.pinPrev[gi];
      assign active = st_r.extPinIrqEns[gi] & pins.pinFuncIrq[gi]
                      & pins.portDirIn[gi];
      assign pinEvt[gi] = active & (((sel == EDGE_RISE) & rise)
                                  | ((sel == EDGE_FALL) & fall)
                                  | ((sel == EDGE_BOTH) & (rise | fall)));
    end
  endgenerate

  assign cmpEvt = src.cmpOut ^ st_r.cmpPrev;

  // ------------------------------------------------------------------
  // Pending requests and priority
  // ------------------------------------------------------------------
  logic [NUM_VEC-1:0] pend;
  logic               anyPend;
  logic               stackFull;
  logic [VIDX_W-1:0]  winIdx;

  always_comb
  begin
    pend          = '0;
    pend[V_EXT0]  = st_r.extPinReqFlags[0] & st_r.extPinIrqEns[0];
    pend[V_CMP]   = st_r.comparatorReqFlag & st_r.comparatorIrqEn;
    pend[V_GRP0]  = st_r.groupReqFlag[0] & st_r.groupIrqEn[0];
    pend[V_EXT1]  = st_r.extPinReqFlags[1] & st_r.extPinIrqEns[1];
    pend[V_GRP1]  = st_r.groupReqFlag[1] & st_r.groupIrqEn[1];
    pend[V_GRP2]  = st_r.groupReqFlag[2] & st_r.groupIrqEn[2];
    pend[V_EXT2]  = st_r.extPinReqFlags[2] & st_r.extPinIrqEns[2];
    pend[V_UART]  = st_r.serial1ReqFlag & st_r.serial1IrqEn;
    winIdx        = '0;
    for (int i = NUM_VEC - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        winIdx = VIDX_W'(i);
      end
    end
  end

  assign anyPend   = |pend;
  assign stackFull = (st_r.sp == SP_W'(STACK_DEPTH));

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  logic                   wrEn;
  logic                   rdPhase;
  logic                   accept;
  logic [REG_W-1:0]       wd;
  logic [REG_W-1:0]       rd;
  logic                   mapped;
  logic [NUM_GRP-1:0]     grpEvt;
  localparam int FLAG_W = 2 * NIB_W + NUM_EXT + NUM_GRP + 4;
  logic [FLAG_W-1:0]      flagsOld;
  logic [FLAG_W-1:0]      flagsNew;

  assign wd      = pwdata[REG_W-1:0];
  assign wrEn    = psel & penable & st_r.ack & pwrite;
  assign rdPhase = psel & penable & ~st_r.ack;
  assign accept  = cpuReq.instrBoundary & ~cpuReq.callPush & ~cpuReq.retPop
                   & st_r.globalIrqEnable & anyPend & ~stackFull;

  always_comb
  begin
    st_nxt              = st_r;
    st_nxt.rsp.pcLoad   = 1'b0;
    st_nxt.rsp.irqTaken = 1'b0;
    st_nxt.rsp.wakeUp   = 1'b0;
    st_nxt.pinPrev      = pins.extIrqPins;
    st_nxt.cmpPrev      = src.cmpOut;
    st_nxt.pullHigh     = pins.pullSel;
    mapped              = 1'b1;
    rd                  = REG_RST;

    // Register read mux
    case (paddr)
      ADDR_PRIM0:
      begin
        rd[P0_GIE]   = st_r.globalIrqEnable;
        rd[P0_EXT_E] = st_r.extPinIrqEns[0];
        rd[P0_CMP_E] = st_r.comparatorIrqEn;
        rd[P0_GRP_E] = st_r.groupIrqEn[0];
        rd[P0_EXT_F] = st_r.extPinReqFlags[0];
        rd[P0_CMP_F] = st_r.comparatorReqFlag;
        rd[P0_GRP_F] = st_r.groupReqFlag[0];
      end
      ADDR_PRIM1:
      begin
        rd[P1_G1_E] = st_r.groupIrqEn[1];
        rd[P1_G2_E] = st_r.groupIrqEn[2];
        rd[P1_G1_F] = st_r.groupReqFlag[1];
        rd[P1_G2_F] = st_r.groupReqFlag[2];
      end
      ADDR_PRIM2:
      begin
        rd[P2_EXT_E] = st_r.extPinIrqEns[1];
        rd[P2_EXT_F] = st_r.extPinReqFlags[1];
      end
      ADDR_EXT2_UART:
      begin
        rd[PAIR_F_HI] = st_r.extPinReqFlags[2];
        rd[PAIR_F_LO] = st_r.serial1ReqFlag;
        rd[PAIR_E_HI] = st_r.extPinIrqEns[2];
        rd[PAIR_E_LO] = st_r.serial1IrqEn;
      end
      ADDR_TGRP0:
      begin
        rd[NIB_F_LSB +: NIB_W] = st_r.g0Flag;
        rd[NIB_E_LSB +: NIB_W] = st_r.g0En;
      end
      ADDR_TGRP1:
      begin
        rd[NIB_F_LSB +: NIB_W] = st_r.g1Flag;
        rd[NIB_E_LSB +: NIB_W] = st_r.g1En;
      end
      ADDR_EE_LVD:
      begin
        rd[PAIR_F_LO +: 2] = st_r.g2Flag;
        rd[PAIR_E_LO +: 2] = st_r.g2En;
      end
      ADDR_EDGE:
      begin
        rd[NUM_EXT*EDGE_W-1:0] = st_r.edgeSelectReg;
      end
      ADDR_STATUS:
      begin
        rd[ST_PEND]             = anyPend;
        rd[ST_FULL]             = stackFull;
        rd[ST_SP_LSB +: SP_W]   = st_r.sp;
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase

    // APB answer: one wait state, data registered
    st_nxt.ack = rdPhase;
    if (rdPhase)
    begin
      st_nxt.rdData = pwrite ? REG_RST : rd;
      st_nxt.slvErr = ~mapped;
    end

    // Software writes
    if (wrEn)
    begin
      case (paddr)
        ADDR_PRIM0:
        begin
          st_nxt.globalIrqEnable   = wd[P0_GIE];
          st_nxt.extPinIrqEns[0]   = wd[P0_EXT_E];
          st_nxt.comparatorIrqEn   = wd[P0_CMP_E];
          st_nxt.groupIrqEn[0]     = wd[P0_GRP_E];
          st_nxt.extPinReqFlags[0] = wd[P0_EXT_F];
          st_nxt.comparatorReqFlag = wd[P0_CMP_F];
          st_nxt.groupReqFlag[0]   = wd[P0_GRP_F];
        end
        ADDR_PRIM1:
        begin
          st_nxt.groupIrqEn[1]   = wd[P1_G1_E];
          st_nxt.groupIrqEn[2]   = wd[P1_G2_E];
          st_nxt.groupReqFlag[1] = wd[P1_G1_F];
          st_nxt.groupReqFlag[2] = wd[P1_G2_F];
        end
        ADDR_PRIM2:
        begin
          st_nxt.extPinIrqEns[1]   = wd[P2_EXT_E];
          st_nxt.extPinReqFlags[1] = wd[P2_EXT_F];
        end
        ADDR_EXT2_UART:
        begin
          st_nxt.extPinReqFlags[2] = wd[PAIR_F_HI];
          st_nxt.serial1ReqFlag    = wd[PAIR_F_LO];
          st_nxt.extPinIrqEns[2]   = wd[PAIR_E_HI];
          st_nxt.serial1IrqEn      = wd[PAIR_E_LO];
        end
        ADDR_TGRP0:
        begin
          st_nxt.g0Flag = wd[NIB_F_LSB +: NIB_W];
          st_nxt.g0En   = wd[NIB_E_LSB +: NIB_W];
        end
        ADDR_TGRP1:
        begin
          st_nxt.g1Flag = wd[NIB_F_LSB +: NIB_W];
          st_nxt.g1En   = wd[NIB_E_LSB +: NIB_W];
        end
        ADDR_EE_LVD:
        begin
          st_nxt.g2Flag = wd[PAIR_F_LO +: 2];
          st_nxt.g2En   = wd[PAIR_E_LO +: 2];
        end
        ADDR_EDGE:
        begin
          st_nxt.edgeSelectReg = wd[NUM_EXT*EDGE_W-1:0];
        end
        default:
        begin
        end
      endcase
    end

    // Stack: return and subroutine call from the core, else interrupt acceptance
    if (cpuReq.retPop && st_r.sp != '0)
    begin
      st_nxt.sp          = st_r.sp - SP_W'(1);
      st_nxt.rsp.pcLoad  = 1'b1;
      st_nxt.rsp.pcValue = st_r.stack[st_r.sp - SP_W'(1)];
    end
    else if (cpuReq.callPush && !stackFull)
    begin
      st_nxt.stack[st_r.sp[SP_W-2:0]] = cpuReq.pcNext;
      st_nxt.sp                       = st_r.sp + SP_W'(1);
    end
    else if (accept)
    begin
      st_nxt.stack[st_r.sp[SP_W-2:0]] = cpuReq.pcNext;
      st_nxt.sp                       = st_r.sp + SP_W'(1);
      st_nxt.rsp.pcLoad               = 1'b1;
      st_nxt.rsp.pcValue              = VEC_BASE + (PC_W'(winIdx) << VEC_SHIFT);
      st_nxt.rsp.irqTaken             = 1'b1;
      st_nxt.rsp.vecIdx               = winIdx;
      st_nxt.globalIrqEnable          = 1'b0;
      case (winIdx)
        V_EXT0:
        begin
          st_nxt.extPinReqFlags[0] = 1'b0;
        end
        V_EXT1:
        begin
          st_nxt.extPinReqFlags[1] = 1'b0;
        end
        V_EXT2:
        begin
          st_nxt.extPinReqFlags[2] = 1'b0;
        end
        V_CMP:
        begin
          st_nxt.comparatorReqFlag = 1'b0;
        end
        V_GRP0:
        begin
          st_nxt.groupReqFlag[0] = 1'b0;
        end
        V_GRP1:
        begin
          st_nxt.groupReqFlag[1] = 1'b0;
        end
        V_GRP2:
        begin
          st_nxt.groupReqFlag[2] = 1'b0;
        end
        default:
        begin
          st_nxt.serial1ReqFlag = 1'b0;
        end
      endcase
    end

    // Hardware events: set wins over any clear
    grpEvt[0] = |(src.grp0Evt & st_nxt.g0En);
    grpEvt[1] = |(src.grp1Evt & st_nxt.g1En);
    grpEvt[2] = |({src.eepromEvt, src.lowVoltEvt} & st_nxt.g2En);
    st_nxt.extPinReqFlags    = st_nxt.extPinReqFlags | pinEvt;
    st_nxt.comparatorReqFlag = st_nxt.comparatorReqFlag | cmpEvt;
    st_nxt.serial1ReqFlag    = st_nxt.serial1ReqFlag | src.serial1Evt;
    st_nxt.g0Flag            = st_nxt.g0Flag | src.grp0Evt;
    st_nxt.g1Flag            = st_nxt.g1Flag | src.grp1Evt;
    st_nxt.g2Flag            = st_nxt.g2Flag | {src.eepromEvt, src.lowVoltEvt};
    st_nxt.groupReqFlag      = st_nxt.groupReqFlag | grpEvt;

    // Wake on a flag that rises now, not on one already set
    flagsOld = {st_r.extPinReqFlags, st_r.comparatorReqFlag, st_r.serial1ReqFlag,
                st_r.groupReqFlag, st_r.g0Flag, st_r.g1Flag, st_r.g2Flag};
    flagsNew = {st_nxt.extPinReqFlags, st_nxt.comparatorReqFlag, st_nxt.serial1ReqFlag,
                st_nxt.groupReqFlag, st_nxt.g0Flag, st_nxt.g1Flag, st_nxt.g2Flag};
    st_nxt.rsp.wakeUp    = cpuReq.lowPower & |(flagsNew & ~flagsOld);
    st_nxt.rsp.stackFull = (st_nxt.sp == SP_W'(STACK_DEPTH));
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prdata     = {{(32-REG_W){1'b0}}, st_r.rdData};
  assign pready     = st_r.ack;
  assign pslverr    = st_r.ack & st_r.slvErr;
  assign cpuRsp     = st_r.rsp;
  assign pullHighEn = st_r.pullHigh;

endmodule
`default_nettype wire

//--- src/mic_pkg.sv
// Constants, field positions and carrier types of the interrupt controller
`default_nettype none
package mic_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int PC_W        = 13;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 4;
  localparam int NUM_EXT     = 3;
  localparam int NUM_GRP     = 3;
  localparam int NUM_VEC     = 8;
  localparam int VIDX_W      = 3;
  localparam int REG_W       = 8;
  localparam int ADDR_W      = 8;

  // ------------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_PRIM0     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_PRIM1     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PRIM2     = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_EXT2_UART = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_TGRP0     = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_TGRP1     = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_EE_LVD    = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_EDGE      = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h20;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  // First primary register
  localparam int P0_GIE   = 0;
  localparam int P0_EXT_E = 1;
  localparam int P0_CMP_E = 2;
  localparam int P0_GRP_E = 3;
  localparam int P0_EXT_F = 4;
  localparam int P0_CMP_F = 5;
  localparam int P0_GRP_F = 6;
  // Second primary register
  localparam int P1_G1_E = 0;
  localparam int P1_G2_E = 1;
  localparam int P1_G1_F = 4;
  localparam int P1_G2_F = 5;
  // Third primary register
  localparam int P2_EXT_E = 1;
  localparam int P2_EXT_F = 5;
  // Two-source registers: flags at 5/4, enables at 1/0
  localparam int PAIR_F_HI = 5;
  localparam int PAIR_F_LO = 4;
  localparam int PAIR_E_HI = 1;
  localparam int PAIR_E_LO = 0;
  // Four-source group registers
  localparam int NIB_F_LSB = 4;
  localparam int NIB_E_LSB = 0;
  localparam int NIB_W     = 4;
  // Edge select and status
  localparam int EDGE_W     = 2;
  localparam int ST_PEND    = 0;
  localparam int ST_FULL    = 1;
  localparam int ST_SP_LSB  = 4;

  localparam logic [REG_W-1:0] REG_RST = 8'h00;

  // ------------------------------------------------------------------
  // Edge select codes
  // ------------------------------------------------------------------
  localparam logic [EDGE_W-1:0] EDGE_OFF  = 2'h0;
  localparam logic [EDGE_W-1:0] EDGE_RISE = 2'h1;
  localparam logic [EDGE_W-1:0] EDGE_FALL = 2'h2;
  localparam logic [EDGE_W-1:0] EDGE_BOTH = 2'h3;

  // ------------------------------------------------------------------
  // Vectors, indexed in acceptance priority (0 highest)
  // ------------------------------------------------------------------
  localparam logic [VIDX_W-1:0] V_EXT0 = 3'h0;
  localparam logic [VIDX_W-1:0] V_CMP  = 3'h1;
  localparam logic [VIDX_W-1:0] V_GRP0 = 3'h2;
  localparam logic [VIDX_W-1:0] V_EXT1 = 3'h3;
  localparam logic [VIDX_W-1:0] V_GRP1 = 3'h4;
  localparam logic [VIDX_W-1:0] V_GRP2 = 3'h5;
  localparam logic [VIDX_W-1:0] V_EXT2 = 3'h6;
  localparam logic [VIDX_W-1:0] V_UART = 3'h7;
  localparam logic [PC_W-1:0]   VEC_BASE  = 13'h0004;
  localparam int                VEC_SHIFT = 2;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [NIB_W-1:0] grp0Evt;
    logic [NIB_W-1:0] grp1Evt;
    logic             eepromEvt;
    logic             lowVoltEvt;
    logic             serial1Evt;
    logic             cmpOut;
  } mic_src_t;

  typedef struct packed {
    logic [NUM_EXT-1:0] extIrqPins;
    logic [NUM_EXT-1:0] pinFuncIrq;
    logic [NUM_EXT-1:0] portDirIn;
    logic [NUM_EXT-1:0] pullSel;
  } mic_pin_t;

  typedef struct packed {
    logic            instrBoundary;
    logic [PC_W-1:0] pcNext;
    logic            callPush;
    logic            retPop;
    logic            lowPower;
  } mic_cpu_req_t;

  typedef struct packed {
    logic              pcLoad;
    logic [PC_W-1:0]   pcValue;
    logic              irqTaken;
    logic [VIDX_W-1:0] vecIdx;
    logic              stackFull;
    logic              wakeUp;
  } mic_cpu_rsp_t;

  typedef struct packed {
    logic                                globalIrqEnable;
    logic [NUM_EXT-1:0]                  extPinIrqEns;
    logic [NUM_EXT-1:0]                  extPinReqFlags;
    logic                                comparatorIrqEn;
    logic                                comparatorReqFlag;
    logic                                serial1IrqEn;
    logic                                serial1ReqFlag;
    logic [NUM_GRP-1:0]                  groupIrqEn;
    logic [NUM_GRP-1:0]                  groupReqFlag;
    logic [NIB_W-1:0]                    g0En;
    logic [NIB_W-1:0]                    g0Flag;
    logic [NIB_W-1:0]                    g1En;
    logic [NIB_W-1:0]                    g1Flag;
    logic [1:0]                          g2En;
    logic [1:0]                          g2Flag;
    logic [NUM_EXT*EDGE_W-1:0]           edgeSelectReg;
    logic [NUM_EXT-1:0]                  pinPrev;
    logic                                cmpPrev;
    logic [STACK_DEPTH-1:0][PC_W-1:0]    stack;
    logic [SP_W-1:0]                     sp;
    mic_cpu_rsp_t                        rsp;
    logic [NUM_EXT-1:0]                  pullHigh;
    logic                                ack;
    logic                                slvErr;
    logic [REG_W-1:0]                    rdData;
  } mic_state_t;

endpackage
`default_nettype wire

//--- bench/mic_checker.sv
// Port assertions of the interrupt controller
`default_nettype none
module mic_checker
  import mic_pkg::*;
(
  input wire logic                        mclk,
  input wire logic                        rst_n,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire mic_pkg::mic_pin_t           pins,
  input wire mic_pkg::mic_cpu_req_t       cpuReq,
  input wire mic_pkg::mic_cpu_rsp_t       cpuRsp,
  input wire logic [mic_pkg::NUM_EXT-1:0] pullHighEn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----
  // Checks
  // ----
  a_one_wait:
    assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_rd_upper:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_vec_addr:
    assert property (cpuRsp.irqTaken |-> cpuRsp.pcLoad && cpuRsp.pcValue ==
      VEC_BASE + 13'(cpuRsp.vecIdx) * 13'h4) else $error("bad vector address");
  a_acc_cause:
    assert property (cpuRsp.irqTaken |-> $past(cpuReq.instrBoundary && !cpuReq.callPush
      && !cpuReq.retPop)) else $error("accept outside boundary");
  a_no_nest:
    assert property (cpuRsp.irqTaken |=> !cpuRsp.irqTaken) else $error("nested accept");
  a_full_block:
    assert property (cpuRsp.stackFull && $past(cpuRsp.stackFull) && !$past(cpuReq.retPop)
      |=> !cpuRsp.irqTaken) else $error("accept while full");
  a_ret_load:
    assert property (cpuRsp.pcLoad && !cpuRsp.irqTaken |-> $past(cpuReq.retPop))
      else $error("load without return");
  a_wake_cause:
    assert property (cpuRsp.wakeUp |-> $past(cpuReq.lowPower)) else $error("stray wake");
  a_pull_keep:
    assert property ($past(rst_n) |-> pullHighEn == $past(pins.pullSel))
      else $error("pull-high lost");
endmodule
bind mic_irq_ctrl mic_checker u_mic_checker (.mclk, .rst_n, .psel, .penable, .prdata,
  .pready, .pins, .cpuReq, .cpuRsp, .pullHighEn);
`default_nettype wire

//--- bench/mic_cpu_model.sv
// Program sequencer model facing the controller
`default_nettype none
module mic_cpu_model
  import mic_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            ctl,
  input  wire mic_pkg::mic_cpu_rsp_t cpuRsp,
  output mic_pkg::mic_cpu_req_t      cpuReq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Sequencer
  // ----
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpuReq <= '0;
    end
    else
    begin
      cpuReq.callPush      <= ctl[0];
      cpuReq.retPop        <= ctl[1];
      cpuReq.lowPower      <= ctl[2];
      cpuReq.instrBoundary <= !cpuRsp.pcLoad && !cpuReq.retPop && !(ctl[3] && cpuReq.pcNext[0]);
      cpuReq.pcNext        <= cpuRsp.pcLoad ? cpuRsp.pcValue : cpuReq.pcNext + 13'h1;
    end
  end
endmodule
`default_nettype wire

//--- bench/mic_irq_ctrl_tb.sv
// Testbench of the interrupt controller
`default_nettype none
module mic_irq_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mic_pkg::*;
  logic            mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr, rdv;
  logic [31:0]     pwdata, prdata;
  logic [3:0]      ctl;
  logic [2:0]      pullHighEn, lastVec;
  mic_src_t        src;
  mic_pin_t        pins;
  mic_cpu_req_t    cpuReq;
  mic_cpu_rsp_t    cpuRsp;
  logic [PC_W-1:0] stk[$], prevPc, expRet;
  int              error_cnt, n_compared, irqCnt, irqExp, wakeCnt, seed, k;
  logic [7:0]      msk [5] = '{8'h33, 8'hff, 8'hff, 8'h33, 8'h3f};
  // ----
  // Harness
  // ----
  mic_irq_ctrl u_mic_irq_ctrl (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .src, .pins, .cpuReq, .cpuRsp, .pullHighEn);
  mic_cpu_model u_mic_cpu_model (.mclk, .rst_n, .ctl, .cpuRsp, .cpuReq);
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic int lfsr(input int s);
    return ((s << 1) | ((s >> 16 ^ s >> 13) & 1)) & 32'h1ffff;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bound(input logic stuck);
    if (stuck)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    bound(pready !== 1'b1);
    rdv = prdata[7:0];
    chk(pslverr, a > 8'h20);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdv, e);
  endtask
  task automatic pulse(input mic_src_t s);
    @(posedge mclk);
    src <= s;
    @(posedge mclk);
    src <= '0;
  endtask
  task automatic setPin(input logic v);
    @(posedge mclk);
    pins.extIrqPins[2] <= v;
    repeat (2) @(posedge mclk);
  endtask
  task automatic cmd(input int b);
    @(posedge mclk);
    ctl[b] <= 1'b1;
    @(posedge mclk);
    ctl[b] <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic quiet();
    repeat (20) @(posedge mclk);
    chk(irqCnt, irqExp);
  endtask
  task automatic take(input logic [2:0] v);
    irqExp++;
    for (int j = 0; j < 40 && irqCnt < irqExp; j++)
      @(posedge mclk);
    bound(irqCnt < irqExp);
    chk(lastVec, v);
  endtask
  // Reference stack and event counts
  always @(posedge mclk)
  begin
    if (cpuRsp.irqTaken === 1'b1)
    begin
      irqCnt++;
      lastVec = cpuRsp.vecIdx;
      stk.push_back(prevPc);
      chk(cpuRsp.pcValue, VEC_BASE + 13'(cpuRsp.vecIdx) * 13'h4);
    end
    else if (cpuRsp.pcLoad === 1'b1)
      chk(cpuRsp.pcValue, expRet);
    if (cpuRsp.wakeUp === 1'b1)
      wakeCnt++;
    if (cpuReq.retPop && stk.size() > 0)
      expRet = stk.pop_back();
    else if (cpuReq.callPush && stk.size() < STACK_DEPTH)
      stk.push_back(cpuReq.pcNext);
    prevPc = cpuReq.pcNext;
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, ctl, src, pins} = '0;
    rst_n = 1'b0;
    seed = 96573;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (k = 0; k < 10; k++)
      rd(8'(4 * k), 8'h00);
    for (k = 0; k < 5; k++)
    begin
      seed = lfsr(seed);
      wr(8'h0c + 8'(4 * k), seed[7:0]);
      rd(8'h0c + 8'(4 * k), seed[7:0] & msk[k]);
      wr(8'h0c + 8'(4 * k), 8'h00);
    end
    pulse(12'hffe);
    rd(8'h0c, 8'h10);
    rd(8'h10, 8'hf0);
    rd(8'h14, 8'hf0);
    rd(8'h18, 8'h30);
    rd(8'h00, 8'h00);
    for (k = 0; k < 4; k++)
      wr(8'h0c + 8'(4 * k), 8'h00);
    wr(8'h00, 8'h09);
    pulse(12'h100);
    quiet();
    wr(8'h00, 8'h08);
    wr(8'h10, 8'h01);
    pulse(12'h100);
    quiet();
    rd(8'h00, 8'h48);
    wr(8'h00, 8'h49);
    take(V_GRP0);
    rd(8'h00, 8'h08);
    rd(8'h10, 8'h11);
    cmd(1);
    wr(8'h10, 8'h00);
    ctl[3] <= 1'b1;
    wr(8'h04, 8'h11);
    wr(8'h0c, 8'h11);
    wr(8'h00, 8'h25);
    take(V_CMP);
    wr(8'h00, 8'h05);
    take(V_GRP1);
    wr(8'h00, 8'h05);
    take(V_UART);
    rd(8'h00, 8'h04);
    repeat (3) cmd(1);
    ctl[3] <= 1'b0;
    pins <= '{extIrqPins: 3'h0, pinFuncIrq: 3'h7, portDirIn: 3'h7, pullSel: seed[2:0]};
    wr(8'h0c, 8'h02);
    for (k = 0; k < 4; k++)
    begin
      wr(8'h1c, 8'(k << 4));
      setPin(1'b1);
      rd(8'h0c, {2'h0, k[0], 5'h02});
      wr(8'h0c, 8'h02);
      setPin(1'b0);
      rd(8'h0c, {2'h0, k[1], 5'h02});
      wr(8'h0c, 8'h02);
    end
    for (k = 1; k < 3; k++)
    begin
      {pins.pinFuncIrq[2], pins.portDirIn[2]} <= 2'(k);
      setPin(1'b1);
      rd(8'h0c, 8'h02);
      setPin(1'b0);
    end
    pins.pinFuncIrq[2] <= 1'b1;
    pins.portDirIn[2] <= 1'b1;
    wr(8'h1c, 8'h10);
    wr(8'h00, 8'h01);
    setPin(1'b1);
    take(V_EXT2);
    rd(8'h0c, 8'h02);
    cmd(1);
    wr(8'h00, 8'h04);
    for (k = 1; k >= 0; k--)
    begin
      @(posedge mclk);
      src.cmpOut <= k[0];
      rd(8'h00, 8'h24);
      wr(8'h00, 8'h04);
    end
    wr(8'h00, 8'h00);
    repeat (8) cmd(0);
    chk(cpuRsp.stackFull, 1'b1);
    rd(8'h20, 8'h82);
    wr(8'h00, 8'h25);
    quiet();
    cmd(1);
    take(V_CMP);
    repeat (8) cmd(1);
    chk(cpuRsp.stackFull, 1'b0);
    rd(8'h20, 8'h00);
    ctl[2] <= 1'b1;
    pulse(12'h008);
    pulse(12'h008);
    repeat (3) @(posedge mclk);
    chk(wakeCnt, 1);
    wr(8'h18, 8'h01);
    wr(8'h04, 8'h02);
    wr(8'h00, 8'h01);
    pulse(12'h004);
    take(V_GRP2);
    rd(8'h18, 8'h11);
    end_of_test();
  end
endmodule
`default_nettype wire
